// ===== verilog/tsar_consts.svh
// constants for the tracking approximation sequencer: offsets, fields, resets, timing
// assumes a single 100 MHz system clock and a plain strobe register port
//
// Functional notes
// - two oscillator clocks, essentially anti-phase
// - step clock is inverted latch clock, delayed
// - register and counter move on step edges
// - compare latched by latch clock, stable meanwhile
// - state: start, twelve result bits, done
// - start active: load midpoint, clear done
// - compare high: clear trial bit, set next
// - compare low: keep trial bit, set next
// - trials strictly msb to lsb, one per step
// - last trial: decide bit zero, set done
// - done and open collector held until restart
// - start and freeze latched on step edge
// - done, freeze high, follow low: count tracks
`ifndef TSAR_CONSTS_SVH
`define TSAR_CONSTS_SVH

// ***********************************************
// register map (byte offsets)
// ***********************************************
`define TSAR_OFS_STATUS     4'h0
`define TSAR_OFS_MASK       4'h4
`define TSAR_OFS_RESULT     4'h8
`define TSAR_OFS_HALF       4'hC

// ***********************************************
// field positions
// ***********************************************
`define TSAR_EV_DONE        0
`define TSAR_EV_TRACK       1
`define TSAR_RES_COMPLETE   12
`define TSAR_RES_VALID      13
`define TSAR_RES_MODE_LO    14
`define TSAR_PIN_REQ_N      0
`define TSAR_PIN_FREEZE     1
`define TSAR_PIN_FOLLOW_N   2
`define TSAR_PIN_CMP        3

// ***********************************************
// reset values
// ***********************************************
`define TSAR_PIN_RST        4'h7
`define TSAR_MASK_RST       2'h0
`define TSAR_HALF_RST       8'h10
`define TSAR_MIDPOINT       12'h800
`define TSAR_MSB_INDEX      4'hB

// ***********************************************
// timing
// ***********************************************
`define TSAR_CLK_PERIOD_NS  10
`define TSAR_GATE_DELAY_NS  25
`define TSAR_GATE_DELAY_CYC ((`TSAR_GATE_DELAY_NS + `TSAR_CLK_PERIOD_NS - 1) / `TSAR_CLK_PERIOD_NS)

`endif

// ===== verilog/tsar_pkg.sv
// types shared by the sequencer and its clock generator
// assumes tsar_consts.svh supplies the numeric constants
package tsar_pkg;

    // ***********************************************
    // sequencer modes
    // ***********************************************
    typedef enum logic [1:0] {
        TSAR_IDLE = 2'b00,
        TSAR_CONV = 2'b01,
        TSAR_DONE = 2'b10
    } tsar_mode_t;

    typedef logic [11:0] tsar_code_t;
    typedef logic [1:0]  tsar_events_t;

endpackage : tsar_pkg

// ===== verilog/tsar_clk_if.sv
// carrier between the sequencer and its two-phase clock generator
// assumes both ends sit on sys_clk
interface tsar_clk_if;
    logic [7:0] half_period;
    logic       latch_clk;
    logic       step_clk;
    logic       latch_en;
    logic       step_en;

    modport gen (
        input  half_period,
        output latch_clk,
        output step_clk,
        output latch_en,
        output step_en
    );

    modport use_side (
        output half_period,
        input  latch_clk,
        input  step_clk,
        input  latch_en,
        input  step_en
    );
endinterface : tsar_clk_if

// ===== verilog/tsar_clkgen.sv
// two-phase clock generator: latch clock and delayed inverted step clock
// assumes sys_clk and an already released active-low reset
`include "tsar_consts.svh"

module tsar_clkgen #(
    parameter int DELAY_CYC = `TSAR_GATE_DELAY_CYC
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // phases
    tsar_clk_if.gen   phase
);
    import tsar_pkg::*;

    localparam logic [7:0] MIN_HALF = 8'(DELAY_CYC + 1);

    typedef struct packed {
        logic [7:0]           cnt;
        logic                 latch_clk;
        logic [DELAY_CYC-1:0] dly;
        logic                 step_clk;
        logic                 latch_en;
        logic                 step_en;
    } tsar_gen_t;

    tsar_gen_t c_q;
    tsar_gen_t c_d;
    logic [7:0] half;

    // ***********************************************
    // phase generation
    // ***********************************************
    always_comb begin
        c_d = c_q;
        // half period must outlast the gate delay or the phases overlap
        half = (phase.half_period < MIN_HALF) ? MIN_HALF : phase.half_period;
        if (c_q.cnt >= half - 8'h01) begin
            c_d.cnt       = 8'h00;
            c_d.latch_clk = ~c_q.latch_clk;
        end else begin
            c_d.cnt = c_q.cnt + 8'h01;
        end
        c_d.dly      = {c_q.dly[DELAY_CYC-2:0], c_q.latch_clk};
        c_d.step_clk = ~c_q.dly[DELAY_CYC-1];
        c_d.latch_en = c_d.latch_clk & ~c_q.latch_clk;
        c_d.step_en  = c_d.step_clk & ~c_q.step_clk;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign phase.latch_clk = c_q.latch_clk;
    assign phase.step_clk  = c_q.step_clk;
    assign phase.latch_en  = c_q.latch_en;
    assign phase.step_en   = c_q.step_en;

endmodule : tsar_clkgen

// ===== verilog/tsar_sequencer.sv
// 12-bit successive approximation sequencer with tracking counter
// assumes an external dac fed from the result and a comparator on the compare pin
//
// Decided for this implementation: the plain strobed port and the register offsets.
`include "tsar_consts.svh"

module tsar_sequencer (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // converter pins
    input  wire logic              conversion_request_n,
    input  wire logic              freeze_pin,
    input  wire logic              follow_mode_n,
    input  wire logic              compare_pin,
    // dac and status outputs
    output logic [11:0]            approximation_register,
    output logic                   complete_q,
    output logic                   complete_open_collector_n_out,
    output logic                   complete_open_collector_n_oe_n,
    // clocks to the comparator latch and the outside
    output logic                   oscillator_timing_pin,
    output logic                   latch_clock_pin,
    output logic                   step_clock_pin,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    // interrupt
    output logic                   irq
);
    import tsar_pkg::*;

    // ***********************************************
    // state
    // ***********************************************
    typedef struct packed {
        logic [3:0]   s1;
        logic [3:0]   s2;
        logic [3:0]   s3;
        logic [3:0]   clean;
        logic         start_n;
        logic         freeze_synced;
        logic         cmp;
        tsar_mode_t   mode;
        logic [3:0]   trial;
        tsar_code_t   result;
        logic         done;
        logic         valid;
        tsar_events_t status;
        tsar_events_t mask;
        logic [7:0]   half;
        logic [31:0]  rdata;
        logic         irq;
        logic         latch_pin;
        logic         step_pin;
        logic         oc_oe_n;
    } tsar_top_t;

    tsar_top_t    c_q;
    tsar_top_t    c_d;
    logic [1:0]   rst_sync_q;
    logic         rst_n;
    logic [3:0]   pins;
    tsar_events_t ev;
    logic [31:0]  rd_val;

    tsar_clk_if   phase ();

    // ***********************************************
    // reset release
    // ***********************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ***********************************************
    // two-phase clock generator
    // ***********************************************
    assign phase.half_period = c_q.half;

    tsar_clkgen u_clkgen (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .phase   (phase)
    );

    // ***********************************************
    // pin gathering
    // ***********************************************
    always_comb begin
        pins                     = 4'h0;
        pins[`TSAR_PIN_REQ_N]    = conversion_request_n;
        pins[`TSAR_PIN_FREEZE]   = freeze_pin;
        pins[`TSAR_PIN_FOLLOW_N] = follow_mode_n;
        pins[`TSAR_PIN_CMP]      = compare_pin;
    end

    // ***********************************************
    // register read mux
    // ***********************************************
    always_comb begin
        rd_val = 32'h0000_0000;
        case (reg_addr)
            `TSAR_OFS_STATUS: begin
                rd_val[1:0] = c_q.status;
            end
            `TSAR_OFS_MASK: begin
                rd_val[1:0] = c_q.mask;
            end
            `TSAR_OFS_RESULT: begin
                rd_val[11:0]                  = c_q.result;
                rd_val[`TSAR_RES_COMPLETE]    = c_q.done;
                rd_val[`TSAR_RES_VALID]       = c_q.valid;
                rd_val[`TSAR_RES_MODE_LO+1 -: 2] = c_q.mode;
            end
            `TSAR_OFS_HALF: begin
                rd_val[7:0] = c_q.half;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // ***********************************************
    // next state
    // ***********************************************
    always_comb begin
        c_d = c_q;
        ev  = 2'h0;

        // three-stage synchronisers; a change counts once stages two and three agree
        c_d.s1 = pins;
        c_d.s2 = c_q.s1;
        c_d.s3 = c_q.s2;
        for (int i = 0; i < 4; i++) begin
            if (c_q.s2[i] == c_q.s3[i]) begin
                c_d.clean[i] = c_q.s3[i];
            end
        end

        // comparator result frozen between latch edges
        if (phase.latch_en) begin
            c_d.cmp = c_q.clean[`TSAR_PIN_CMP];
        end

        // all sequencing advances only on the step clock edge
        if (phase.step_en) begin
            // inputs take effect one step edge after being latched
            c_d.start_n       = c_q.clean[`TSAR_PIN_REQ_N];
            c_d.freeze_synced = c_q.clean[`TSAR_PIN_FREEZE];
            if (!c_q.start_n) begin
                c_d.result = `TSAR_MIDPOINT;
                c_d.done   = 1'b0;
                c_d.trial  = `TSAR_MSB_INDEX;
                c_d.mode   = TSAR_CONV;
                c_d.valid  = 1'b0;
            end else begin
                case (c_q.mode)
                    TSAR_CONV: begin
                        // comparator high means the dac overshoots the input
                        if (c_q.cmp) begin
                            c_d.result[c_q.trial] = 1'b0;
                        end
                        if (c_q.trial != 4'h0) begin
                            c_d.result[c_q.trial - 4'h1] = 1'b1;
                            c_d.trial = c_q.trial - 4'h1;
                        end else begin
                            c_d.done  = 1'b1;
                            c_d.valid = 1'b1;
                            c_d.mode  = TSAR_DONE;
                            ev[`TSAR_EV_DONE] = 1'b1;
                        end
                    end
                    TSAR_DONE: begin
                        // done stays until the next start request
                        c_d.done = 1'b1;
                        if (c_q.freeze_synced && !c_q.clean[`TSAR_PIN_FOLLOW_N]) begin
                            // counter wraps at the ends, as the toggle chain does
                            if (c_q.cmp) begin
                                c_d.result = c_q.result - 12'h001;
                            end else begin
                                c_d.result = c_q.result + 12'h001;
                            end
                            ev[`TSAR_EV_TRACK] = 1'b1;
                        end
                    end
                    default: begin
                        c_d.mode = TSAR_IDLE;
                    end
                endcase
            end
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                `TSAR_OFS_MASK: begin
                    c_d.mask = reg_wdata[1:0];
                end
                `TSAR_OFS_HALF: begin
                    c_d.half = reg_wdata[7:0];
                end
                default: begin
                    c_d.half = c_q.half;
                end
            endcase
        end

        // read clears status; a new event in the same cycle survives
        if (reg_rd && reg_addr == `TSAR_OFS_STATUS) begin
            c_d.status = ev;
        end else begin
            c_d.status = c_q.status | ev;
        end
        c_d.rdata = reg_rd ? rd_val : 32'h0000_0000;
        c_d.irq   = |(c_d.status & c_d.mask);

        // pin copies of the phases and the open-collector enable
        c_d.latch_pin = phase.latch_clk;
        c_d.step_pin  = phase.step_clk;
        c_d.oc_oe_n   = ~c_d.done;
    end

    // ***********************************************
    // state register
    // ***********************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            c_q               <= '0;
            c_q.s1            <= `TSAR_PIN_RST;
            c_q.s2            <= `TSAR_PIN_RST;
            c_q.s3            <= `TSAR_PIN_RST;
            c_q.clean         <= `TSAR_PIN_RST;
            c_q.start_n       <= 1'b1;
            c_q.freeze_synced <= 1'b1;
            c_q.mode          <= TSAR_IDLE;
            c_q.mask          <= `TSAR_MASK_RST;
            c_q.half          <= `TSAR_HALF_RST;
            c_q.oc_oe_n       <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    // ***********************************************
    // outputs
    // ***********************************************
    assign approximation_register         = c_q.result;
    assign complete_q                     = c_q.done;
    assign complete_open_collector_n_out  = 1'b0;
    assign complete_open_collector_n_oe_n = c_q.oc_oe_n;
    assign oscillator_timing_pin          = c_q.latch_pin;
    assign latch_clock_pin                = c_q.latch_pin;
    assign step_clock_pin                 = c_q.step_pin;
    assign reg_rdata                      = c_q.rdata;
    assign irq                            = c_q.irq;

endmodule : tsar_sequencer

// ===== test/tsar_far_model.sv
// dac plus latching comparator facing the sequencer
// assumes the latch pin and the dac code come from the sequencer top
module tsar_far_model (
    // clock and latch phase
    input wire logic        sys_clk,
    input wire logic        latch_clock_pin,
    // dac code and analog level
    input wire logic [11:0] approximation_register,
    input int               analog_level,
    // comparator output
    output logic            compare_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // comparator
    // ****
    initial compare_pin = 1'b0;
    // transparent while latch low, frozen while high, so the step edge sees a steady bit
    always @(posedge sys_clk) begin
        if (!latch_clock_pin) begin
            compare_pin <= ({20'h00000, approximation_register} > analog_level);
        end
    end
endmodule : tsar_far_model

// ===== test/tsar_monitor.sv
// concurrent checks on the sequencer top ports
// assumes a bind into tsar_sequencer, one sys_clk domain
module tsar_monitor (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // converter side
    input wire logic        conversion_request_n,
    input wire logic [11:0] approximation_register,
    input wire logic        complete_q,
    input wire logic        complete_open_collector_n_out,
    input wire logic        complete_open_collector_n_oe_n,
    input wire logic        latch_clock_pin,
    input wire logic        step_clock_pin,
    // register side
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] prev_q;
    logic [11:0] half_w;
    logic [2:0]  sp_q;
    logic [3:0]  alive_q;
    logic [7:0]  since_req_q;
    logic        rise_w;
    // ****
    // helpers
    // ****
    assign half_w = (prev_q & (~prev_q + 12'h001)) >> 1;
    assign rise_w = (step_clock_pin & ~sp_q[0]) | (sp_q[0] & ~sp_q[1]) | (sp_q[1] & ~sp_q[2]);
    always_ff @(posedge sys_clk) begin
        prev_q <= approximation_register;
        sp_q <= {sp_q[1:0], step_clock_pin};
    end
    // alive count hides the reset-time history from the phase check
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alive_q <= 4'h0;
            since_req_q <= 8'hFF;
        end else begin
            alive_q <= (alive_q == 4'hF) ? alive_q : alive_q + 4'h1;
            since_req_q <= !conversion_request_n ? 8'h00 : since_req_q + {7'h00, since_req_q != 8'hFF};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ****
    // assertions
    // ****
    a_oc_follows_done: assert property (complete_open_collector_n_oe_n == !complete_q)
        else $error("open collector enable differs from done");
    a_oc_drive_low: assert property (complete_open_collector_n_out == 1'b0)
        else $error("open collector data not low");
    a_step_lags_latch: assert property ((alive_q == 4'hF) |-> step_clock_pin == !$past(latch_clock_pin, 4))
        else $error("step clock not delayed inverse of latch clock");
    a_code_on_step: assert property ((approximation_register != prev_q) |-> rise_w or (##[1:2] $rose(step_clock_pin)))
        else $error("code moved away from a step edge");
    a_trial_order: assert property ((approximation_register != prev_q) && !complete_q && !$past(complete_q)
        |-> approximation_register == 12'h800 || approximation_register == prev_q + half_w
        || approximation_register == prev_q - half_w)
        else $error("trial step out of order");
    a_done_after_lsb: assert property ($rose(complete_q) |-> $past(approximation_register[0])
        && (approximation_register | 12'h001) == $past(approximation_register))
        else $error("done not raised from bit zero trial");
    a_restart_mid: assert property ($fell(complete_q) |-> approximation_register == 12'h800
        && since_req_q < 8'hC8)
        else $error("done cleared without start or midpoint");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_track_unit: assert property (complete_q && $past(complete_q) && (approximation_register != prev_q)
        |-> approximation_register == prev_q + 12'h001 || approximation_register == prev_q - 12'h001)
        else $error("tracking step not one lsb");
    c_done: cover property ($rose(complete_q));
    c_restart: cover property ($fell(complete_q));
    c_irq: cover property ($rose(irq));
    c_track: cover property (complete_q && approximation_register != prev_q);
endmodule : tsar_monitor

// ===== test/tsar_testbench.sv
// self-checking bench for the approximation sequencer
// assumes the far-side model on the compare pin and the monitor bound below
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, reset_n, conversion_request_n, freeze_pin, follow_mode_n, compare_pin;
    logic [11:0] approximation_register;
    logic        complete_q, oc_out, oc_oe_n, osc_pin, latch_clock_pin, step_clock_pin, irq;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic        reg_wr, reg_rd;
    int          analog_level, failures, total_checks, cycles, a, c, d;
    tsar_sequencer tsar_sequencer_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .conversion_request_n(conversion_request_n), .freeze_pin(freeze_pin),
        .follow_mode_n(follow_mode_n), .compare_pin(compare_pin),
        .approximation_register(approximation_register), .complete_q(complete_q),
        .complete_open_collector_n_out(oc_out), .complete_open_collector_n_oe_n(oc_oe_n),
        .oscillator_timing_pin(osc_pin), .latch_clock_pin(latch_clock_pin),
        .step_clock_pin(step_clock_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    tsar_far_model tsar_far_model_inst (.sys_clk(sys_clk), .latch_clock_pin(latch_clock_pin),
        .approximation_register(approximation_register), .analog_level(analog_level),
        .compare_pin(compare_pin));
    // ****
    // tasks
    // ****
    always #5 sys_clk = ~sys_clk;
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= dt;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ad);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    function automatic int sar_model(input int level);
        int r;
        r = 0;
        for (int b = 11; b >= 0; b--) begin
            r = r | (1 << b);
            if (r > level) begin
                r = r & ~(1 << b);
            end
        end
        return r;
    endfunction : sar_model
    // level stays put for the whole conversion, else the trials chase a moving input
    task automatic convert(input int level);
        int n;
        analog_level <= level;
        conversion_request_n <= 1'b0;
        repeat (80) @(posedge sys_clk);
        #1;
        check(approximation_register, 12'h800);
        check(complete_q, 1'b0);
        conversion_request_n <= 1'b1;
        n = 0;
        while (complete_q !== 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(n < 1000, 1'b1);
        check(approximation_register, sar_model(level));
        check(oc_oe_n, 1'b0);
        check(irq, 1'b1);
        wr(4'h8, 32'hFFFFFFFF);
        rd(4'h8);
        check(v, 32'hB000 | sar_model(level));
        rd(4'h0);
        check(v & 32'h1, 32'h1);
    endtask : convert
    // ****
    // sequence
    // ****
    initial begin
        {sys_clk, reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {conversion_request_n, freeze_pin, follow_mode_n} = 3'h7;
        analog_level = 0;
        void'($urandom(49088));
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rd(4'h4);
        check(v, 32'h0);
        rd(4'hC);
        check(v, 32'h10);
        rd(4'h2);
        check(v, 32'h0);
        wr(4'hC, 32'hC);
        rd(4'hC);
        check(v, 32'hC);
        wr(4'h4, 32'h1);
        for (int i = 0; i < 4; i++) begin
            convert(i == 0 ? 0 : i == 1 ? 4095 : $urandom % 4096);
        end
        rd(4'h0);
        check(v, 32'h0);
        check(irq, 1'b0);
        a = analog_level > 2047 ? analog_level - 20 : analog_level + 20;
        analog_level <= a;
        follow_mode_n <= 1'b0;
        repeat (800) @(posedge sys_clk);
        #1;
        d = approximation_register - a;
        check(d * d <= 1, 1'b1);
        check(complete_q, 1'b1);
        rd(4'h0);
        check(v & 32'h2, 32'h2);
        freeze_pin <= 1'b0;
        // freeze needs the synchroniser plus two step edges before it bites
        repeat (60) @(posedge sys_clk);
        c = approximation_register;
        repeat (100) @(posedge sys_clk);
        check(approximation_register, c);
        freeze_pin <= 1'b1;
        convert($urandom % 4096);
        conclude();
    end
endmodule : testbench
bind tsar_sequencer tsar_monitor tsar_monitor_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .conversion_request_n(conversion_request_n), .approximation_register(approximation_register),
    .complete_q(complete_q), .complete_open_collector_n_out(complete_open_collector_n_out),
    .complete_open_collector_n_oe_n(complete_open_collector_n_oe_n),
    .latch_clock_pin(latch_clock_pin), .step_clock_pin(step_clock_pin), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
